// File: hw/fsir_regs.sv
// Purpose: forwarding control, forwarding status and interrupt control registers
// Assumes: register port from serial control bus decoder, engines on sys_clk
// Notes:   read data appears one cycle after the read strobe

`timescale 1ns/1ps
`default_nettype none

module fsir_regs (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    // register port
    input  wire logic [fsir_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [fsir_pkg::DATA_W-1:0] reg_wdata,
    output logic      [fsir_pkg::DATA_W-1:0] reg_rdata,
    output logic                          reg_rvalid,
    // forwarding engines
    input  wire logic [1:0]               frame_done,
    input  wire logic [1:0]               sync_lost,
    input  wire logic [1:0]               sync_ok,
    output logic                          out0_round_robin_enable,
    output logic                          out1_round_robin_enable,
    output logic      [1:0]               out0_sync_mode,
    output logic      [1:0]               out1_sync_mode,
    // interrupt sources and output
    input  wire logic                     tx0_irq_status,
    input  wire logic                     tx1_irq_status,
    input  wire logic                     rx3_irq_status,
    output logic                          irq_pending,
    output logic                          irq_out
);
    import fsir_pkg::*;

    typedef struct packed {
        logic [1:0]        rr;
        logic [1:0]        mode0;
        logic [1:0]        mode1;
        logic              int_en;
        logic              tx1_irq_enable;
        logic              tx0_irq_enable;
        logic              receive_port3_irq_enable;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              pending;
        logic              irq;
    } fsir_regs_state_t;

    fsir_regs_state_t s_r;
    fsir_regs_state_t s_nxt;
    logic             rst_meta_r;
    logic             rst_n;
    logic             pend_c;
    logic             wr_low;
    logic             wr_sync;
    logic             wr_irq;

    fsir_stat_if st ();

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ==========================================================
    // reset release
    // assert is immediate, release waits two clocks to avoid metastable exit
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ==========================================================
    // status tracker
    assign st.mode_active = {s_r.mode1 != FSIR_SYNC_OFF, s_r.mode0 != FSIR_SYNC_OFF};
    assign st.frame_done  = frame_done;
    assign st.sync_lost   = sync_lost;
    assign st.sync_ok     = sync_ok;
    assign st.clear_flags = reg_rd && hit(reg_addr, OFS_FWD_STATUS);

    fsir_port_status u_status (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .st      (st.stat)
    );

    // ==========================================================
    // register writes and reads
    assign wr_low  = reg_wr && hit(reg_addr, OFS_FWD_CTL_LOW);
    assign wr_sync = reg_wr && hit(reg_addr, OFS_FWD_CTL_SYNC);
    assign wr_irq  = reg_wr && hit(reg_addr, OFS_IRQ_CONTROL);

    assign pend_c = (tx1_irq_status && s_r.tx1_irq_enable)
                 || (tx0_irq_status && s_r.tx0_irq_enable)
                 || (rx3_irq_status && s_r.receive_port3_irq_enable);

    always_comb begin
        s_nxt = s_r;
        if (wr_low) begin
            s_nxt.rr = {reg_wdata[RR1_BIT], reg_wdata[RR0_BIT]};
        end
        // sync mode fields
        // mixing with round-robin is left to software, nothing blocks it here
        if (wr_sync) begin
            s_nxt.mode0 = reg_wdata[SYNC0_LSB +: 2];
            s_nxt.mode1 = reg_wdata[SYNC1_LSB +: 2];
        end
        if (wr_irq) begin
            s_nxt.int_en = reg_wdata[INT_EN_BIT];
            s_nxt.tx1_irq_enable           = reg_wdata[IE_TX1_BIT];
            s_nxt.tx0_irq_enable           = reg_wdata[IE_TX0_BIT];
            s_nxt.receive_port3_irq_enable = reg_wdata[RX3_EN_BIT];
        end
        s_nxt.rvalid = reg_rd;
        s_nxt.rdata  = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_FWD_CTL_LOW: begin
                    s_nxt.rdata[RR1_BIT] = s_r.rr[1];
                    s_nxt.rdata[RR0_BIT] = s_r.rr[0];
                end
                OFS_FWD_CTL_SYNC: begin
                    s_nxt.rdata[SYNC1_LSB +: 2] = s_r.mode1;
                    s_nxt.rdata[SYNC0_LSB +: 2] = s_r.mode0;
                end
                OFS_FWD_STATUS: begin
                    // value before the clear lands this same edge
                    s_nxt.rdata[LOST1_BIT] = st.lost[1];
                    s_nxt.rdata[LOST0_BIT] = st.lost[0];
                    s_nxt.rdata[LOCK1_BIT] = st.locked[1];
                    s_nxt.rdata[LOCK0_BIT] = st.locked[0];
                end
                OFS_IRQ_CONTROL: begin
                    s_nxt.rdata[INT_EN_BIT] = s_r.int_en;
                    s_nxt.rdata[IE_TX1_BIT] = s_r.tx1_irq_enable;
                    s_nxt.rdata[IE_TX0_BIT] = s_r.tx0_irq_enable;
                    s_nxt.rdata[RX3_EN_BIT] = s_r.receive_port3_irq_enable;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
        s_nxt.pending = pend_c;
        s_nxt.irq = s_r.int_en && pend_c;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.rr     <= RR_RESET;
            s_r.mode0  <= SYNC_RESET;
            s_r.mode1  <= SYNC_RESET;
            s_r.int_en <= IE_RESET;
            s_r.tx1_irq_enable           <= IE_RESET;
            s_r.tx0_irq_enable           <= IE_RESET;
            s_r.receive_port3_irq_enable <= IE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata               = s_r.rdata;
    assign reg_rvalid              = s_r.rvalid;
    assign out0_round_robin_enable = s_r.rr[0];
    assign out1_round_robin_enable = s_r.rr[1];
    assign out0_sync_mode          = s_r.mode0;
    assign out1_sync_mode          = s_r.mode1;
    assign irq_pending             = s_r.pending;
    assign irq_out                 = s_r.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_RR_RESET: assert property (
        $rose(rst_n) |-> (s_r.rr == RR_RESET))
        else $error("round-robin enables not set after reset");
    AST_RR_WRITE: assert property (
        wr_low |=> (out1_round_robin_enable == $past(reg_wdata[RR1_BIT]))
                && (out0_round_robin_enable == $past(reg_wdata[RR0_BIT])))
        else $error("round-robin write not taken");
    AST_SYNC_MODE_WRITE: assert property (
        wr_sync |=> (out1_sync_mode == $past(reg_wdata[5:4]))
                 && (out0_sync_mode == $past(reg_wdata[3:2])))
        else $error("sync mode write not taken");
    AST_GLOBAL_GATE: assert property (
        (!s_r.int_en) |=> !irq_out)
        else $error("irq asserted with global enable clear");
    AST_TX_ENABLE: assert property (
        (wr_irq ##1 !reg_wr ##1 (reg_rd && hit(reg_addr, OFS_IRQ_CONTROL) && !wr_irq)) |=>
            (reg_rdata[5:4] == $past(reg_wdata[5:4], 3)))
        else $error("transmitter enables did not read back");
    AST_RESERVED_ZERO: assert property (
        (reg_rd && hit(reg_addr, OFS_IRQ_CONTROL)) |=>
            (reg_rdata[6] == 1'b0)
            && (reg_rdata[RX3_EN_BIT] == $past(s_r.receive_port3_irq_enable)))
        else $error("irq control read back wrong");
    AST_PENDING: assert property (
        (rx3_irq_status && s_r.receive_port3_irq_enable) |=> irq_pending)
        else $error("pending not set for enabled source");
    AST_IRQ_OUT: assert property (
        (s_r.int_en && pend_c) |=> irq_out ##1 (irq_out == $past(s_r.int_en && pend_c)))
        else $error("irq output does not follow enabled pending");
    AST_STATUS_READ: assert property (
        (reg_rd && hit(reg_addr, OFS_FWD_STATUS)) |=>
            (reg_rdata[3:2] == $past(st.lost)) && reg_rvalid)
        else $error("status read did not return flags before clear");
    AST_PENDING_UNGATED: assert property (
        (tx0_irq_status && s_r.tx0_irq_enable && !s_r.int_en) |=> irq_pending)
        else $error("pending depends on the global enable");
    AST_TX1_SOURCE: assert property (
        (tx1_irq_status && s_r.tx1_irq_enable) |=> irq_pending)
        else $error("port 1 transmitter source not seen");
    AST_ALL_MASKED: assert property (
        (!s_r.tx1_irq_enable && !s_r.tx0_irq_enable && !s_r.receive_port3_irq_enable)
            |=> !irq_pending)
        else $error("pending with every source masked");
    AST_IRQ_DROP: assert property (
        (!pend_c) |=> !irq_out)
        else $error("irq output held without a pending source");

    COV_IRQ:  cover property (s_r.int_en && pend_c ##1 irq_out);
    COV_READ: cover property (reg_rd && hit(reg_addr, OFS_FWD_STATUS) && st.lost != 2'h0);
    COV_UNGATED: cover property (s_r.pending && !s_r.int_en);

endmodule

`default_nettype wire

// File: hw/fsir_pkg.sv
// Purpose: constants for the forwarding status and interrupt control registers
// Assumes: 8-bit register port behind the serial control bus decoder
// Notes:   offsets, field positions and reset values are defined here; the bench and some checks repeat them as literals

`default_nettype none

package fsir_pkg;

    // ==========================================================
    // register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_FWD_CTL_LOW  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_FWD_CTL_SYNC = 8'h21;
    localparam logic [ADDR_W-1:0] OFS_FWD_STATUS   = 8'h22;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL  = 8'h23;

    // ==========================================================
    // field positions
    localparam int unsigned RR0_BIT    = 0;
    localparam int unsigned RR1_BIT    = 1;
    localparam int unsigned SYNC0_LSB  = 2;
    localparam int unsigned SYNC1_LSB  = 4;
    localparam int unsigned LOCK0_BIT  = 0;
    localparam int unsigned LOCK1_BIT  = 1;
    localparam int unsigned LOST0_BIT  = 2;
    localparam int unsigned LOST1_BIT  = 3;
    localparam int unsigned RX3_EN_BIT = 3;
    localparam int unsigned IE_TX0_BIT = 4;
    localparam int unsigned IE_TX1_BIT = 5;
    localparam int unsigned INT_EN_BIT = 7;

    // ==========================================================
    // reset values
    localparam logic [1:0] RR_RESET   = 2'h3;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic       IE_RESET   = 1'b0;

    // ==========================================================
    // synchronized forwarding modes
    typedef enum logic [1:0] {
        FSIR_SYNC_OFF        = 2'h0,
        FSIR_SYNC_BASIC      = 2'h1,
        FSIR_SYNC_INTERLEAVE = 2'h2,
        FSIR_SYNC_CONCAT     = 2'h3
    } fsir_sync_mode_t;

endpackage

`default_nettype wire

// File: hw/fsir_stat_if.sv
// Purpose: carries per-port forwarding status between register top and tracker
// Assumes: both ends on the system clock
// Notes:   bit 0 is output port 0, bit 1 is output port 1

`timescale 1ns/1ps
`default_nettype none

interface fsir_stat_if;
    logic [1:0] mode_active;
    logic [1:0] frame_done;
    logic [1:0] sync_lost;
    logic [1:0] sync_ok;
    logic       clear_flags;
    logic [1:0] lost;
    logic [1:0] locked;

    modport ctrl (
        output mode_active, frame_done, sync_lost, sync_ok, clear_flags,
        input  lost, locked
    );
    modport stat (
        input  mode_active, frame_done, sync_lost, sync_ok, clear_flags,
        output lost, locked
    );
endinterface

`default_nettype wire

// File: hw/fsir_port_status.sv
// Purpose: per-port lock status and sticky sync-lost flags
// Assumes: engine strobes are one-cycle pulses on the system clock
// Notes:   flags clear on status read; a new loss in that cycle wins

`timescale 1ns/1ps
`default_nettype none

module fsir_port_status (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // status carrier
    fsir_stat_if.stat st
);
    import fsir_pkg::*;

    typedef struct packed {
        logic [1:0] lost;
        logic [1:0] armed;
        logic [1:0] locked;
    } fsir_ps_state_t;

    fsir_ps_state_t s_r;
    fsir_ps_state_t s_nxt;
    logic [1:0]     lost_set;

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        // arm after frame
        // arming drops with the mode so a re-enable needs a fresh good frame
        s_nxt.armed = st.mode_active & (s_r.armed | st.frame_done);
        lost_set = st.mode_active & s_r.armed & st.sync_lost;
        s_nxt.lost = (st.clear_flags ? 2'h0 : s_r.lost) | lost_set;
        s_nxt.locked = st.mode_active & st.sync_ok;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign st.lost   = s_r.lost;
    assign st.locked = s_r.locked;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_LOST_SET: assert property (
        (st.sync_lost[1] && st.mode_active[1] && s_r.armed[1]) |=> st.lost[1])
        else $error("port 1 loss did not set its flag");
    AST_LOST_NEEDS_ARM: assert property (
        ((s_r.lost & ~$past(s_r.lost) & ~$past(s_r.armed)) == 2'h0))
        else $error("sync lost flag set before a good frame");
    AST_CLEAR_ON_READ: assert property (
        (st.clear_flags && lost_set == 2'h0) |=> (st.lost == 2'h0))
        else $error("status read did not clear the flags");
    AST_LOCK_FOLLOW: assert property (
        (st.mode_active[0] && st.sync_ok[0]) |=> st.locked[0] ##1 1'b1)
        else $error("port 0 lock not reported");
    AST_LOCK_OFF: assert property (
        (st.mode_active == 2'h0) [*2] |-> (st.locked == 2'h0))
        else $error("lock shown while sync forwarding disabled");

    COV_LOST: cover property ($rose(st.lost[0]));
    COV_LOCK: cover property ($rose(st.locked[1]));

endmodule

`default_nettype wire

// File: sim/fsir_host_model.sv
// Purpose: host controller model driving the register port
// Assumes: one request per call, strobes launched after a rising edge
// Notes:   idle address and data show the inverse of the last value

`timescale 1ns/1ps
`default_nettype none

module fsir_host_model (
    // clock
    input  wire logic                        sys_clk,
    // register port
    output logic      [fsir_pkg::ADDR_W-1:0] reg_addr,
    output logic                             reg_wr,
    output logic                             reg_rd,
    output logic      [fsir_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic [fsir_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        reg_rvalid
);
    import fsir_pkg::*;

    initial begin
        reg_addr  = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = '0;
    end

    // ==========================================================
    // bus cycles
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // answer lands on the taking edge, one cycle after the strobe; bounded wait
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic ok);
        int n;
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        d  = '0;
        for (n = 0; n < 4 && !ok; n++) begin
            @(negedge sys_clk);
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata;
            end
        end
    endtask
endmodule

`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench for the forwarding and interrupt registers
// Assumes: engine strobes are driven by the bench at the rising edge
// Notes:   expectations follow the register map, not the design outputs

`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import fsir_pkg::*;

    logic              sys_clk;
    logic              reset_n;
    logic [ADDR_W-1:0] reg_addr;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic              reg_rvalid;
    logic [1:0]        frame_done;
    logic [1:0]        sync_lost;
    logic [1:0]        sync_ok;
    logic [2:0]        src;
    logic              rr0;
    logic              rr1;
    logic [1:0]        sm0;
    logic [1:0]        sm1;
    logic              irq_pending;
    logic              irq_out;
    int                bad_count;
    int                checked;

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    fsir_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    fsir_regs u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .frame_done(frame_done), .sync_lost(sync_lost),
        .sync_ok(sync_ok), .out0_round_robin_enable(rr0), .out1_round_robin_enable(rr1),
        .out0_sync_mode(sm0), .out1_sync_mode(sm1), .tx0_irq_status(src[0]),
        .tx1_irq_status(src[1]), .rx3_irq_status(src[2]), .irq_pending(irq_pending),
        .irq_out(irq_out));

    // ==========================================================
    // shared helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        logic       ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            bad_count++;
            $display("[ERR] %0t read answer missing", $time);
            conclude();
        end else begin
            chk(d, exp, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic pulse(input logic [1:0] fd, input logic [1:0] sl);
        @(posedge sys_clk);
        frame_done <= fd;
        sync_lost  <= sl;
        @(posedge sys_clk);
        frame_done <= 2'h0;
        sync_lost  <= 2'h0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk({6'h0, rr1, rr0}, 8'h03, "rr outputs");
        rchk(8'h20, 8'h03, "rr reset");
        rchk(8'h21, 8'h00, "mode reset");
        rchk(8'h22, 8'h00, "status reset");
        rchk(8'h23, 8'h00, "irq ctl reset");
        rchk(8'h55, 8'h00, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_modes();
        int m;
        // round-robin off before any sync mode
        u_host.wr(8'h20, 8'h00);
        cyc(1);
        chk({6'h0, rr1, rr0}, 8'h00, "rr cleared");
        for (m = 0; m < 4; m++) begin
            u_host.wr(8'h21, 8'(m << 2 | (3 - m) << 4));
            cyc(1);
            chk({4'h0, sm1, sm0}, 8'((3 - m) << 2 | m), "mode outputs");
        end
        u_host.wr(8'h21, 8'hff);
        rchk(8'h21, 8'h3c, "mode readback");
        u_host.wr(8'h30, 8'h00);
        rchk(8'h21, 8'h3c, "unmapped write");
        $display("test modes done");
    endtask

    task automatic t_lock();
        u_host.wr(8'h21, 8'h00);
        sync_ok <= 2'h3;
        rchk(8'h22, 8'h00, "locked while off");
        u_host.wr(8'h21, 8'h24);
        rchk(8'h22, 8'h03, "locked both");
        @(posedge sys_clk);
        sync_ok <= 2'h1;
        rchk(8'h22, 8'h01, "locked port0");
        $display("test lock done");
    endtask

    task automatic t_lost();
        pulse(2'h0, 2'h3);
        rchk(8'h22, 8'h01, "loss before frame");
        pulse(2'h3, 2'h0);
        pulse(2'h0, 2'h2);
        rchk(8'h22, 8'h09, "loss port1");
        rchk(8'h22, 8'h01, "cleared by read");
        pulse(2'h0, 2'h1);
        rchk(8'h22, 8'h05, "loss port0");
        u_host.wr(8'h21, 8'h00);
        u_host.wr(8'h21, 8'h24);
        pulse(2'h0, 2'h1);
        rchk(8'h22, 8'h01, "rearm needed");
        $display("test lost done");
    endtask

    task automatic t_irq();
        logic [7:0] en [3];
        int         i;
        en = '{8'h10, 8'h20, 8'h08};
        u_host.wr(8'h23, 8'hff);
        rchk(8'h23, 8'hb8, "irq ctl readback");
        for (i = 0; i < 3; i++) begin
            u_host.wr(8'h23, 8'h38 & ~en[i] | 8'h80);
            src <= 3'(1 << i);
            cyc(3);
            chk({6'h0, irq_pending, irq_out}, 8'h00, "masked source");
            u_host.wr(8'h23, en[i] | 8'h80);
            cyc(3);
            chk({6'h0, irq_pending, irq_out}, 8'h03, "enabled source");
            u_host.wr(8'h23, en[i]);
            cyc(3);
            chk({6'h0, irq_pending, irq_out}, 8'h02, "global off");
            u_host.wr(8'h23, en[i] | 8'h80);
            src <= 3'h0;
            cyc(3);
            chk({6'h0, irq_pending, irq_out}, 8'h00, "source cleared");
        end
        $display("test irq done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        reset_n    = 1'b0;
        frame_done = 2'h0;
        sync_lost  = 2'h0;
        sync_ok    = 2'h0;
        src        = 3'h0;
        bad_count  = 0;
        checked    = 0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(4);
        t_reset();
        t_modes();
        t_lock();
        t_lost();
        t_irq();
        conclude();
    end
endmodule

`default_nettype wire
